/* File: design/rtq_pkg.sv */
// package: register map, field positions, reset values and state codes of the trace qualifier block
package rtq_pkg;

    // ==========================================
    // register map (byte addresses, one word each)
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] COUNT_OFFSET  = 8'h08;

    // ==========================================
    // field positions
    localparam int CTRL_CACHE_EN_BIT   = 0;
    localparam int STAT_HALTED_BIT     = 0;
    localparam int STAT_ARMED_BIT      = 1;
    localparam int STAT_RESETPH_BIT    = 2;
    localparam int STAT_MARK_BIT       = 3;
    localparam int STAT_BUSST_LSB      = 4;

    // ==========================================
    // reset values
    localparam logic CTRL_CACHE_EN_RESET = 1'b1;

    // ==========================================
    // sequencer-mark pulse lengths in clocks, minus one
    localparam logic [1:0] MARK_LEFT_BOUNDARY  = 2'h0;
    localparam logic [1:0] MARK_LEFT_PENDING   = 2'h1;
    localparam logic [1:0] MARK_LEFT_EXCEPTION = 2'h2;

    // ==========================================
    // state codes
    typedef enum logic [1:0] {
        MK_IDLE = 2'b00,
        MK_RUN  = 2'b01,
        MK_HALT = 2'b10
    } rtq_mark_st_t;

    typedef enum logic [1:0] {
        BS_IDLE  = 2'b00,
        BS_START = 2'b01,
        BS_VALID = 2'b10
    } rtq_bus_st_t;

endpackage

/* File: design/rtq_mark_if.sv */
// interface: sequencer-mark and pipeline-reload between core logic and the falling-edge pin stage
interface rtq_mark_if;
    logic markReq;
    logic reloadReq;
    logic mark;
    logic reload;

    modport core (output markReq, output reloadReq, input mark, input reload);
    modport pins (input markReq, input reloadReq, output mark, output reload);
endinterface

/* File: design/rtq_pin_stage.sv */
// module: falling-edge output stage for sequencer-mark and pipeline-reload
module rtq_pin_stage (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic ce,
    rtq_mark_if.pins  pins
);

    typedef struct packed {
        logic mark;
        logic reload;
    } rtq_pin_state_t;

    rtq_pin_state_t s;
    rtq_pin_state_t next_s;

    // ==========================================
    // next value: copy requests, hold while the clock enable is low
    always_comb begin
        next_s = s;
        if (ce) begin
            next_s.mark   = pins.markReq;
            next_s.reload = pins.reloadReq;
        end
    end

    // outputs only ever move on the falling edge, so a sampler on the rising edge sees them settled
    always_ff @(negedge clock or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pins.mark   = s.mark;
    assign pins.reload = s.reload;

    // ==========================================
    // checks
    fall_edge_mark_a: assert property (@(negedge clock) disable iff (!rstn)
        ce |=> (pins.mark == $past(pins.markReq)) && (pins.reload == $past(pins.reloadReq)))
        else $error("mark or reload did not follow its request at the falling edge");

endmodule

/* File: design/rtq_trace_core.sv */
// module: processor-side trace visibility logic: sequencer mark, pipeline reload, cycle strobes, halt
// Function
// - after a double bus fault, hold sequencer mark high until reset.
// - a second bus error before the first handler instruction runs halts the core.
// - bus or address error during reset vector fetch or first prefetch halts.
// - an external cycle drives address and cycle-begin, then address-valid.
// - a cache or holding-register read hit aborts the cycle without address-valid; here only while the CTRL cache enable bit is set.
// - address bits 7..0 bypass translation and appear on the bus every access.
// - every write reaches the external bus, cache hit or not.
// - mark lasts one clock at boundary, two when pending, three on exception.
// - mark and reload change only on falling clock edges.
// - reload is raised whenever the sequencer asks for a pipeline refill, except while halted.
//
// Local design decisions: the AHB-Lite slave port and the register addresses.
module rtq_trace_core (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        ce,
    // sequencer events from the core
    input  wire logic        evBoundary,
    input  wire logic        evPending,
    input  wire logic        evException,
    input  wire logic        evTableSearch,
    input  wire logic        busError,
    input  wire logic        addrError,
    input  wire logic        handlerStart,
    input  wire logic        resetVecDone,
    input  wire logic        refillReq,
    // access requests from the core
    input  wire logic        accReq,
    input  wire logic        accWrite,
    input  wire logic [31:0] accAddr,
    input  wire logic [23:0] accPhysHigh,
    input  wire logic [31:0] accWrData,
    input  wire logic        cacheHit,
    input  wire logic        accDone,
    output logic             accReady,
    output logic             accAck,
    // trace-visible pins
    output logic             seqMark,
    output logic             pipeReload,
    output logic             externalCycleBeginN,
    output logic             addressValidStrobeN,
    output logic [31:0]      addrOut,
    output logic [31:0]      dataOut,
    output logic             dataOe,
    output logic             coreHalted,
    // register bus
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);

    typedef struct packed {
        rtq_pkg::rtq_mark_st_t mk;
        logic [1:0]            markLeft;
        logic                  markOn;
        logic                  reloadOn;
        logic                  faultArmed;
        logic                  resetPhase;
        rtq_pkg::rtq_bus_st_t  bs;
        logic                  cycStartN;
        logic                  asN;
        logic                  isWrite;
        logic [31:0]           addr;
        logic [31:0]           wrData;
        logic                  cacheEn;
        logic [15:0]           instrCount;
        logic                  dpValid;
        logic                  dpWrite;
        logic [7:0]            dpAddr;
        logic [31:0]           rdata;
    } rtq_core_state_t;

    localparam rtq_core_state_t RESET_STATE = '{
        mk: rtq_pkg::MK_IDLE, markLeft: 2'h0, markOn: 1'b0, reloadOn: 1'b0,
        faultArmed: 1'b0, resetPhase: 1'b1, bs: rtq_pkg::BS_IDLE, cycStartN: 1'b1,
        asN: 1'b1, isWrite: 1'b0, addr: 32'h0000_0000, wrData: 32'h0000_0000,
        cacheEn: rtq_pkg::CTRL_CACHE_EN_RESET, instrCount: 16'h0000,
        dpValid: 1'b0, dpWrite: 1'b0, dpAddr: 8'h00, rdata: 32'h0000_0000};

    rtq_core_state_t s;
    rtq_core_state_t next_s;
    rtq_mark_if      markPins ();

    logic halted;
    logic excEvent;
    logic haltTrig;
    logic accept;
    logic readHit;

    // ==========================================
    // event decode
    assign halted   = (s.mk == rtq_pkg::MK_HALT);
    assign excEvent = evException | evTableSearch | busError | addrError;
    // second bus error while armed, or any bus or address error while fetching reset vectors
    assign haltTrig = (busError & s.faultArmed)
                    | (s.resetPhase & (busError | addrError));
    assign accept   = accReq & (s.bs == rtq_pkg::BS_IDLE) & !halted;
    // writes never count as hits: the write-through caches must show every store
    assign readHit  = cacheHit & !s.isWrite & s.cacheEn;

    // handshake back to the core
    assign accReady  = (s.bs == rtq_pkg::BS_IDLE) & !halted;
    assign accAck    = ((s.bs == rtq_pkg::BS_START) & readHit) | ((s.bs == rtq_pkg::BS_VALID) & accDone);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // ==========================================
    // next state
    always_comb begin
        next_s = s;
        if (ce) begin
            // ---- sequencer mark: halt overrides any pulse in progress
            if (halted || haltTrig) begin
                next_s.mk     = rtq_pkg::MK_HALT;
                next_s.markOn = 1'b1;
            end else if (s.mk == rtq_pkg::MK_RUN) begin
                // events during a pulse are dropped; the core issues one per boundary
                if (s.markLeft == 2'h0) begin
                    next_s.mk     = rtq_pkg::MK_IDLE;
                    next_s.markOn = 1'b0;
                end else begin
                    next_s.markLeft = s.markLeft - 2'h1;
                end
            end else if (excEvent) begin
                next_s.mk       = rtq_pkg::MK_RUN;
                next_s.markOn   = 1'b1;
                next_s.markLeft = rtq_pkg::MARK_LEFT_EXCEPTION;
            end else if (evPending) begin
                next_s.mk       = rtq_pkg::MK_RUN;
                next_s.markOn   = 1'b1;
                next_s.markLeft = rtq_pkg::MARK_LEFT_PENDING;
            end else if (evBoundary) begin
                next_s.mk       = rtq_pkg::MK_RUN;
                next_s.markOn   = 1'b1;
                next_s.markLeft = rtq_pkg::MARK_LEFT_BOUNDARY;
            end

            // ---- pipeline reload follows the refill request, silenced once halted
            next_s.reloadOn = refillReq & !halted;

            // ---- fault tracking: a fresh bus error arms, reaching the handler disarms
            if (busError) begin
                next_s.faultArmed = 1'b1;
            end else if (handlerStart) begin
                next_s.faultArmed = 1'b0;
            end
            if (resetVecDone) begin
                next_s.resetPhase = 1'b0;
            end

            // ---- external cycle sequencing
            case (s.bs)
                rtq_pkg::BS_IDLE: begin
                    if (accept) begin
                        next_s.bs      = rtq_pkg::BS_START;
                        next_s.cycStartN = 1'b0;
                        next_s.isWrite = accWrite;
                        // low byte is untranslated and always reaches the pins
                        next_s.addr    = {accPhysHigh, accAddr[7:0]};
                        next_s.wrData  = accWrData;
                    end
                end
                rtq_pkg::BS_START: begin
                    next_s.cycStartN = 1'b1;
                    if (readHit) begin
                        next_s.bs = rtq_pkg::BS_IDLE;
                    end else begin
                        next_s.bs  = rtq_pkg::BS_VALID;
                        next_s.asN = 1'b0;
                    end
                end
                rtq_pkg::BS_VALID: begin
                    if (accDone) begin
                        next_s.bs  = rtq_pkg::BS_IDLE;
                        next_s.asN = 1'b1;
                    end
                end
                default: begin
                    next_s.bs        = rtq_pkg::BS_IDLE;
                    next_s.cycStartN = 1'b1;
                    next_s.asN  = 1'b1;
                end
            endcase

            // ---- register bus data phase: writes land before the read mux below
            if (s.dpValid && s.dpWrite) begin
                if (s.dpAddr == rtq_pkg::CTRL_OFFSET) begin
                    next_s.cacheEn = hwdata[rtq_pkg::CTRL_CACHE_EN_BIT];
                end else if (s.dpAddr == rtq_pkg::COUNT_OFFSET) begin
                    next_s.instrCount = 16'h0000;
                end
            end
            // a boundary counted in the clearing cycle is kept
            if (!halted && !haltTrig && s.mk == rtq_pkg::MK_IDLE && !excEvent && (evPending || evBoundary)) begin
                next_s.instrCount = next_s.instrCount + 16'h0001;
            end

            // ---- register bus address phase: read data is loaded into a flop here
            next_s.dpValid = hsel & htrans[1] & hready;
            next_s.dpWrite = hwrite;
            next_s.dpAddr  = {haddr[7:2], 2'b00};
            if (hsel && htrans[1] && hready && !hwrite) begin
                if (haddr[7:0] == rtq_pkg::CTRL_OFFSET) begin
                    next_s.rdata = {31'h0000_0000, next_s.cacheEn};
                end else if (haddr[7:0] == rtq_pkg::STATUS_OFFSET) begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rdata[rtq_pkg::STAT_HALTED_BIT]  = halted;
                    next_s.rdata[rtq_pkg::STAT_ARMED_BIT]   = s.faultArmed;
                    next_s.rdata[rtq_pkg::STAT_RESETPH_BIT] = s.resetPhase;
                    next_s.rdata[rtq_pkg::STAT_MARK_BIT]    = s.markOn;
                    next_s.rdata[rtq_pkg::STAT_BUSST_LSB +: 2] = s.bs;
                end else if (haddr[7:0] == rtq_pkg::COUNT_OFFSET) begin
                    next_s.rdata = {16'h0000, next_s.instrCount};
                end else begin
                    next_s.rdata = 32'h0000_0000;
                end
            end
        end
    end

    // single state register; reset loads constants only
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s <= RESET_STATE;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================
    // falling-edge pin stage
    assign markPins.markReq   = s.markOn;
    assign markPins.reloadReq = s.reloadOn;

    rtq_pin_stage pinStage (
        .clock (clock),
        .rstn  (rstn),
        .ce    (ce),
        .pins  (markPins)
    );

    // ==========================================
    // pins
    assign seqMark             = markPins.mark;
    assign pipeReload          = markPins.reload;
    assign externalCycleBeginN = s.cycStartN;
    assign addressValidStrobeN = s.asN;
    assign addrOut             = s.addr;
    assign dataOut             = s.wrData;
    assign dataOe              = s.isWrite & (s.bs == rtq_pkg::BS_VALID);
    assign coreHalted          = halted;
    assign hrdata              = s.rdata;

    // ==========================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn || !ce);

    halt_hold_a: assert property (halted |=> halted && s.markOn)
        else $error("halted state or mark dropped without reset");
    double_fault_a: assert property (s.faultArmed && busError |=> halted && s.markOn)
        else $error("second bus error did not halt");
    reset_fault_a: assert property (s.resetPhase && addrError |=> halted)
        else $error("fault during reset fetch did not halt");
    cycle_open_a: assert property (accept |=> !s.cycStartN && s.asN ##1 s.cycStartN)
        else $error("cycle-begin strobe not a one-clock pulse ahead of address-valid");
    hit_abort_a: assert property (s.bs == rtq_pkg::BS_START && readHit |=> s.asN && s.bs == rtq_pkg::BS_IDLE)
        else $error("address-valid asserted on a cache hit");
    low_byte_a: assert property (accept |=> addrOut[7:0] == $past(accAddr[7:0]))
        else $error("low address byte not presented");
    write_out_a: assert property (accept && accWrite |=> ##1 !s.asN && dataOe)
        else $error("write did not reach the external bus");
    pend_mark_a: assert property (s.mk == rtq_pkg::MK_IDLE && evPending && !excEvent && !halted
        |=> (s.markOn [*2] ##1 !s.markOn) or (##[0:2] halted))
        else $error("pending mark not two clocks");
    exc_mark_a: assert property (s.mk == rtq_pkg::MK_IDLE && excEvent && !haltTrig && !halted
        |=> (s.markOn [*3] ##1 !s.markOn) or (##[0:3] halted))
        else $error("exception mark not three clocks");
    refill_a: assert property (refillReq && !halted |=> s.reloadOn && markPins.reload)
        else $error("refill request not shown on reload");

endmodule

/* File: tb/rtq_trace_model.sv */
// partner model: external trace decode logic that feeds a logic analyzer
module rtq_trace_model (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic mark,
    input  wire logic reload,
    input  wire logic cycleBeginN,
    input  wire logic addrValidN,
    input  wire logic syncCycleEnd,
    input  wire logic asyncAckLow,
    input  wire logic asyncAckHigh,
    output logic      sample,
    output logic      coreStoppedFlag,
    output logic      flowBreakFlag,
    output logic      faultEntryFlag,
    output logic      instrDoneFlag,
    output logic      cycleLaunchMark
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] runLen;
    logic [2:0] lastLen;
    logic       markQ;
    logic       startQ;
    logic       hitQ;
    logic       termQ;
    logic       reloadQ;
    logic       fell;
    // ==========================================
    // rising-edge capture, where the core's falling-edge outputs are stable
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            {runLen, lastLen, markQ, startQ, hitQ, termQ, reloadQ} <= '0;
        end else begin
            markQ   <= mark;
            lastLen <= runLen;
            runLen  <= mark ? ((runLen == 3'h7) ? runLen : runLen + 3'h1) : 3'h0;
            startQ  <= !cycleBeginN;
            hitQ    <= startQ && addrValidN; // cycle begun but never validated: a hit
            termQ   <= !addrValidN && (syncCycleEnd || asyncAckLow || asyncAckHigh);
            reloadQ <= reload;
        end
    end
    assign fell = !markQ && (lastLen != 3'h0);
    // ==========================================
    // flags and qualifier publish on falling edges; a cycle start alone never qualifies
    always_ff @(negedge clock or negedge rstn) begin
        if (!rstn) begin
            {sample, coreStoppedFlag, flowBreakFlag, faultEntryFlag, instrDoneFlag, cycleLaunchMark} <= '0;
        end else begin
            sample          <= termQ || hitQ || fell || (runLen > 3'h3 && !coreStoppedFlag);
            coreStoppedFlag <= coreStoppedFlag || (runLen > 3'h3);
            flowBreakFlag   <= reloadQ || (flowBreakFlag && !sample); // reload never qualifies
            cycleLaunchMark <= startQ;
            if (fell) begin
                instrDoneFlag  <= (lastLen == 3'h1);
                faultEntryFlag <= (lastLen == 3'h2) || (lastLen == 3'h3);
            end
        end
    end
endmodule

/* File: tb/realtime_trace_qualifier_test.sv */
// testbench: register bus, access port, sequencer marks and halt of the trace core
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module realtime_trace_qualifier_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, rstn = 0, ce = 1, handlerStart = 0, resetVecDone = 0, busError = 0, addrError = 0;
    logic refillReq = 0, accReq = 0, accWrite = 0, cacheHit = 0, hsel = 0, hwrite = 0;
    logic [3:0]  ev = 4'h0;
    logic [2:0]  term = 3'h0;
    logic [1:0]  htrans = 2'h0;
    logic [23:0] accPhysHigh = 24'h00_0000;
    logic [31:0] accAddr = 0, accWrData = 0, haddr = 0, hwdata = 0, r;
    logic accReady, accAck, seqMark, pipeReload, cycStartN, asN, dataOe, coreHalted, hreadyout, hresp;
    logic sample, fStop, fFlow, fFault, fInstr, fLaunch;
    logic [31:0] addrOut, dataOut, hrdata;
    int n_mismatch = 0, samples_checked = 0, nSample = 0, s0;
    // ==========================================
    // clock and analyzer: one stored sample per qualified falling edge
    always #12.5 clock = ~clock;
    always @(posedge clock) if (sample === 1'b1) nSample++;
    rtq_trace_core u_rtq_trace_core (.clock(clock), .rstn(rstn), .ce(ce), .evBoundary(ev[0]), .evPending(ev[1]),
        .evException(ev[2]), .evTableSearch(ev[3]), .busError(busError), .addrError(addrError),
        .handlerStart(handlerStart), .resetVecDone(resetVecDone), .refillReq(refillReq), .accReq(accReq),
        .accWrite(accWrite), .accAddr(accAddr), .accPhysHigh(accPhysHigh), .accWrData(accWrData),
        .cacheHit(cacheHit), .accDone(|term), .accReady(accReady), .accAck(accAck), .seqMark(seqMark),
        .pipeReload(pipeReload), .externalCycleBeginN(cycStartN), .addressValidStrobeN(asN), .addrOut(addrOut),
        .dataOut(dataOut), .dataOe(dataOe), .coreHalted(coreHalted), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    rtq_trace_model u_rtq_trace_model (.clock(clock), .rstn(rstn), .mark(seqMark), .reload(pipeReload),
        .cycleBeginN(cycStartN), .addrValidN(asN), .syncCycleEnd(term[0]), .asyncAckLow(term[1]),
        .asyncAckHigh(term[2]), .sample(sample), .coreStoppedFlag(fStop), .flowBreakFlag(fFlow),
        .faultEntryFlag(fFault), .instrDoneFlag(fInstr), .cycleLaunchMark(fLaunch));
    // ==========================================
    // closing report, reached from the end of the run or a spent wait
    task end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // bus wait bounded so a stuck slave ends the run
    task waitReady;
        int k;
        k = 0;
        do begin @(posedge clock); k++; end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin n_mismatch++; end_of_test; end
    endtask
    // one single AHB-Lite word transfer; read data taken at the data-phase edge
    task ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
        waitReady;
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        waitReady;
        rd = hrdata;
    endtask
    task rdchk(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000, r);
        `CHK(r, exp)
    endtask
    // one core access; the far side ends misses on the chosen termination line
    task acc(input logic w, input logic hit, input logic [31:0] a, input logic [31:0] d, input logic [2:0] t);
        @(posedge clock);
        `CHK(accReady, 1'b1)
        accReq <= 1'b1; accWrite <= w; accAddr <= a; accWrData <= d; accPhysHigh <= 24'hab_cdef;
        s0 = nSample;
        @(posedge clock); accReq <= 1'b0; cacheHit <= hit; #1;
        `CHK(cycStartN, 1'b0)
        `CHK(addrOut, {24'hab_cdef, a[7:0]})
        if (hit && !w) begin
            `CHK(accAck, 1'b1)
            @(posedge clock); cacheHit <= 1'b0; #1;
            `CHK(asN, 1'b1)
        end else begin
            @(posedge clock); cacheHit <= 1'b0; term <= t; #1;
            `CHK({cycStartN, asN, accAck, dataOe}, {1'b1, 1'b0, 1'b1, w})
            if (w) `CHK(dataOut, d)
            @(posedge clock); term <= 3'h0; #1;
            `CHK(fLaunch, 1'b1)
            `CHK(asN, 1'b1)
        end
        repeat (3) @(posedge clock); #1;
        `CHK(nSample, s0 + 1)
    endtask
    // one sequencer event; mark width counted at rising edges, then decoded flags
    task markChk(input int which, input int len, input logic instr);
        int k, n;
        @(posedge clock); ev <= 4'b0001 << which;
        @(posedge clock); ev <= 4'h0;
        n = 0; k = 0;
        do begin @(posedge clock); k++; if (seqMark === 1'b1) n++; end while ((n == 0 || seqMark === 1'b1) && k < 20);
        if (k >= 20) begin n_mismatch++; end_of_test; end
        `CHK(n, len)
        repeat (2) @(posedge clock); #1;
        `CHK({fInstr, fFault}, {instr, !instr})
    endtask
    // one-clock pulse: 0 vector done, 1 refill, 2 bus error, 3 address error, 4 handler start
    task pulse(input int which);
        @(posedge clock);
        case (which)
            0: resetVecDone <= 1'b1;
            1: refillReq <= 1'b1;
            2: busError <= 1'b1;
            3: addrError <= 1'b1;
            default: handlerStart <= 1'b1;
        endcase
        @(posedge clock);
        {resetVecDone, refillReq, busError, addrError, handlerStart} <= 5'h00;
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (10) @(posedge clock); #1;
        `CHK({seqMark, cycStartN, asN, coreHalted, accReady, hreadyout, hresp}, 7'b0110110)
        @(posedge clock); rstn <= 1'b1;
        pulse(0);
        rdchk(32'(rtq_pkg::CTRL_OFFSET), {31'h0, rtq_pkg::CTRL_CACHE_EN_RESET});
        rdchk(32'(rtq_pkg::COUNT_OFFSET), 32'h0000_0000);
        rdchk(32'h0000_000c, 32'h0000_0000); // unmapped word reads zero
        ahb(1'b1, 32'(rtq_pkg::CTRL_OFFSET), 32'h0000_0000, r);
        rdchk(32'(rtq_pkg::CTRL_OFFSET), 32'h0000_0000);
        ahb(1'b1, 32'(rtq_pkg::CTRL_OFFSET), 32'h0000_0001, r);
        markChk(0, 1, 1'b1);
        markChk(1, 2, 1'b0);
        markChk(2, 3, 1'b0);
        markChk(3, 3, 1'b0);
        rdchk(32'(rtq_pkg::COUNT_OFFSET), 32'h0000_0002); // one- and two-clock marks only
        ahb(1'b1, 32'(rtq_pkg::COUNT_OFFSET), 32'h0000_0000, r);
        rdchk(32'(rtq_pkg::COUNT_OFFSET), 32'h0000_0000);
        // a refill shows on the reload pin and sets flow-break without a sample
        s0 = nSample;
        pulse(1);
        @(posedge clock);
        `CHK(pipeReload, 1'b1)
        repeat (3) @(posedge clock); #1;
        `CHK({fFlow, nSample}, {1'b1, s0})
        acc(1'b0, 1'b0, 32'h1234_5678, 32'h0000_0000, 3'b001);
        `CHK(fFlow, 1'b0)
        acc(1'b0, 1'b1, 32'h0000_00c4, 32'h0000_0000, 3'b010);
        acc(1'b1, 1'b1, 32'h0bad_0011, 32'hcafe_f00d, 3'b100);
        // a bus error arms, reaching the handler disarms, a second error before the handler halts
        pulse(2);
        ahb(1'b0, 32'(rtq_pkg::STATUS_OFFSET), 32'h0000_0000, r);
        `CHK(r[rtq_pkg::STAT_ARMED_BIT], 1'b1)
        pulse(4);
        ahb(1'b0, 32'(rtq_pkg::STATUS_OFFSET), 32'h0000_0000, r);
        `CHK({r[rtq_pkg::STAT_HALTED_BIT], r[rtq_pkg::STAT_ARMED_BIT]}, 2'b00)
        pulse(2);
        repeat (6) @(posedge clock);
        pulse(2);
        repeat (8) @(posedge clock); #1;
        `CHK({coreHalted, accReady, seqMark}, 3'b101)
        `CHK(fStop, 1'b1)
        @(posedge clock); rstn <= 1'b0;
        repeat (3) @(posedge clock); #1;
        `CHK({seqMark, coreHalted, fStop, fFlow}, 4'b0000)
        @(posedge clock); rstn <= 1'b1;
        pulse(3);
        repeat (3) @(posedge clock); #1;
        `CHK(coreHalted, 1'b1)
        end_of_test;
    end
endmodule
